// File: fnsc_synth_ctrl.sv
// synthesizer control: serial port, four latches, modulus buffer, lock detect, mux pin
// How it works
// RULE1: serial bits shift into 24-bit register on serial clock rise, MSB first.
// RULE2: latch strobe rise copies word to latch chosen by two lowest bits.
// RULE3: select 00 loads the integer/fraction divider register.
// RULE4: select 01 reference, 10 control, 11 noise and spur register.
// RULE5: host keeps fraction numerator not above the loaded modulus.
// RULE6: wide-loop bit forces maximum pump current, else programmed current.
// RULE7: fastlock mux setting pulls pin low while wide-loop bit is one.
// RULE8: load-control bit stores resync delay and keeps modulus unchanged.
// RULE9: mux source comes from reference register bits 22 to 20.
// RULE10: precision 0 locks after 24 comparator cycles with error below 15 ns.
// RULE11: lock holds until new channel or an error above 30 ns.
// RULE12: precision 1 needs 40 cycles with error within 15 ns.
// RULE13: host picks 8/9 prescaler above 2 GHz.
// RULE14: host keeps integer value at least 31 or 91 per prescaler.
// RULE15: host programs reference counter with 1 through 15 only.
// RULE16: new modulus applies only after a later divider register write.
// RULE17: control bit 2 holds counters in reset.
// RULE18: control bit 3 three-states the charge pump.
// RULE19: control bit 4 powers down; registers keep their contents.
// RULE20: power-down loads counters, three-states pump, resets lock; port still works.
// RULE21: control bit 6 sets phase detector polarity.
// RULE22: control bits 7 to 10 give pump current when fastlock is off.
// RULE23: bit 11 low uses reference falling edge; high uses both edges.
// RULE24: low-spur mode dithers; other modes do not; lowest noise biases pump.
// RULE25: host writes zeros to reserved bits.
// RULE26: host writes every register after power-up before trusting outputs.
`timescale 1ns/1ps
`default_nettype none
module fnsc_synth_ctrl (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic serial_clk_in,
    input wire logic serial_data_in,
    input wire logic latch_strobe_in,
    input wire logic reference_input_in,
    input wire logic phase_comparator_up_in,
    input wire logic phase_comparator_dn_in,
    output var fnsc_pkg::fnsc_cfg_t synth_cfg_out,
    output logic lock_detect_out,
    output logic mux_output_pin_out,
    output logic mux_output_pin_oe_n_out
);
    import fnsc_pkg::*;

    logic [5:0] sync1_q;
    logic [5:0] sync2_q;
    logic [2:0] prev_q;
    logic sclk_s, sdata_s, strobe_s, ref_s, err_s;
    logic sclk_rise, strobe_rise, ref_edge;
    logic [23:0] shift_q;
    logic [23:0] r0_q, r1_q, r2_q, r3_q;
    logic [11:0] mod_pend_q, mod_act_q, resync_q;
    logic new_channel, pwr_dn;
    logic [3:0] err_cnt_q;
    logic [5:0] ld_cnt_q;
    logic [5:0] ld_target;
    logic err_small, err_big;
    fnsc_ld_state_t ld_state_q;
    logic [4:0] ns_mode;

    // two-stage synchronisers for every pin input
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            sync1_q <= 6'h00;
            sync2_q <= 6'h00;
            prev_q <= 3'h0;
        end else begin
            sync1_q <= {phase_comparator_dn_in, phase_comparator_up_in, reference_input_in,
                        latch_strobe_in, serial_data_in, serial_clk_in};
            sync2_q <= sync1_q;
            prev_q <= {sync2_q[3], sync2_q[2], sync2_q[0]};
        end
    end

    assign sclk_s = sync2_q[0];
    assign sdata_s = sync2_q[1];
    assign strobe_s = sync2_q[2];
    assign ref_s = sync2_q[3];
    assign err_s = sync2_q[4] | sync2_q[5];
    assign sclk_rise = sclk_s & ~prev_q[0];
    assign strobe_rise = strobe_s & ~prev_q[1];
    // falling reference edge always active, rising one too with the doubler
    assign ref_edge = (~ref_s & prev_q[2]) | (r2_q[R2_DOUBLER] & ref_s & ~prev_q[2]); // RULE23
    assign new_channel = strobe_rise && (shift_q[1:0] == SEL_DIV);
    assign pwr_dn = r2_q[R2_PWR_DN];

    // serial shift register, keeps running during power-down
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            shift_q <= REG_RST;
        end else if (sclk_rise) begin
            shift_q <= {shift_q[22:0], sdata_s}; // RULE1 RULE20
        end
    end

    // latch transfer and modulus double buffer
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            r0_q <= REG_RST;
            r1_q <= REG_RST;
            r2_q <= REG_RST;
            r3_q <= REG_RST;
            mod_pend_q <= 12'h000;
            mod_act_q <= 12'h000;
            resync_q <= 12'h000;
        end else if (strobe_rise) begin // RULE2
            case (shift_q[1:0])
                SEL_DIV: begin
                    r0_q <= shift_q; // RULE3
                    mod_act_q <= mod_pend_q; // RULE16
                end
                SEL_REF: begin
                    r1_q <= shift_q; // RULE4
                    if (shift_q[R1_LOAD]) begin
                        resync_q <= shift_q[R1_MOD_LSB +: 12]; // RULE8
                    end else begin
                        mod_pend_q <= shift_q[R1_MOD_LSB +: 12];
                    end
                end
                SEL_CTRL: r2_q <= shift_q; // RULE4 RULE19
                SEL_NS: r3_q <= shift_q; // RULE4
                default: ;
            endcase
        end
    end

    // phase error width within the current comparator period
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in || ref_edge) begin
            err_cnt_q <= 4'h0;
        end else if (err_s && err_cnt_q != 4'hf) begin
            err_cnt_q <= err_cnt_q + 4'h1;
        end
    end

    assign err_small = err_cnt_q <= LD_OK_CYC;
    assign err_big = err_cnt_q > LD_LOSE_CYC;
    assign ld_target = r2_q[R2_LOCK_PREC] ? LD_CNT_HI : LD_CNT_LO; // RULE10 RULE12

    // digital lock detect
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in || pwr_dn || new_channel) begin // RULE11 RULE20
            ld_state_q <= LD_SEEK;
            ld_cnt_q <= 6'h00;
        end else begin
            case (ld_state_q)
                LD_SEEK: begin
                    if (ref_edge && !err_small) begin
                        ld_cnt_q <= 6'h00;
                    end else if (ref_edge && ld_cnt_q + 6'h01 == ld_target) begin
                        ld_state_q <= LD_HELD; // RULE10 RULE12
                        ld_cnt_q <= 6'h00;
                    end else if (ref_edge) begin
                        ld_cnt_q <= ld_cnt_q + 6'h01;
                    end
                end
                LD_HELD: begin
                    if (err_big) begin
                        ld_state_q <= LD_SEEK; // RULE11
                    end
                end
                default: ld_state_q <= LD_SEEK;
            endcase
        end
    end

    assign lock_detect_out = (ld_state_q == LD_HELD);
    assign ns_mode = {r3_q[R3_MODE_HI_LSB +: 4], r3_q[R3_MODE_LO]};

    // decoded configuration towards the analog and counter sections
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            synth_cfg_out <= '0;
        end else begin
            synth_cfg_out.int_value <= r0_q[R0_INT_LSB +: 9];
            synth_cfg_out.fraction_numerator <= r0_q[R0_FRACTION_NUMERATOR_LSB +: 12];
            synth_cfg_out.fraction_modulus <= mod_act_q;
            synth_cfg_out.resync_delay <= resync_q;
            synth_cfg_out.ref_count <= r1_q[R1_RCNT_LSB +: 4];
            synth_cfg_out.prescaler_select <= r1_q[R1_PRESCALER];
            synth_cfg_out.cp_current <= r0_q[R0_WIDE_LOOP] ? CP_MAX
                                        : r2_q[R2_CP_LSB +: 4]; // RULE6 RULE22
            synth_cfg_out.cp_tristate <= r2_q[R2_CP_TRI] | pwr_dn; // RULE18 RULE20
            synth_cfg_out.counter_reset <= r2_q[R2_CNT_RST] | pwr_dn; // RULE17 RULE20
            synth_cfg_out.power_down <= pwr_dn; // RULE19
            synth_cfg_out.pd_polarity <= r2_q[R2_POLARITY]; // RULE21
            synth_cfg_out.ref_doubler <= r2_q[R2_DOUBLER]; // RULE23
            synth_cfg_out.resync_setting <= r2_q[R2_RESYNC_LSB +: 4];
            synth_cfg_out.dither_en <= (ns_mode == NS_LOW_SPUR); // RULE24
            synth_cfg_out.cp_low_noise <= (ns_mode == NS_LOWEST); // RULE24
        end
    end

    // multiplexer pin: open-drain fastlock switch or driven lock flag
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            mux_output_pin_out <= 1'b0;
            mux_output_pin_oe_n_out <= 1'b1;
        end else begin
            case (r1_q[R1_MUX_LSB +: 3]) // RULE9
                MUX_FASTLOCK: begin
                    mux_output_pin_out <= 1'b0;
                    mux_output_pin_oe_n_out <= ~r0_q[R0_WIDE_LOOP]; // RULE7
                end
                MUX_LOCK: begin
                    mux_output_pin_out <= lock_detect_out;
                    mux_output_pin_oe_n_out <= 1'b0;
                end
                default: begin
                    mux_output_pin_out <= 1'b0;
                    mux_output_pin_oe_n_out <= 1'b1;
                end
            endcase
        end
    end

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);

    a_shift_msb_first: assert property ( // RULE1
        sclk_rise |=> shift_q == {$past(shift_q[22:0]), $past(sdata_s)})
        else $error("shift register did not take the bit");
    a_latch_divider: assert property ( // RULE2 RULE3
        strobe_rise && shift_q[1:0] == SEL_DIV |=> r0_q == $past(shift_q) && $stable(r1_q))
        else $error("divider latch not loaded");
    a_latch_control: assert property ( // RULE4
        strobe_rise && shift_q[1:0] == SEL_CTRL |=> r2_q == $past(shift_q) && $stable(r3_q))
        else $error("control latch not loaded");
    a_cp_current: assert property ( // RULE6 RULE22
        ##1 synth_cfg_out.cp_current ==
        ($past(r0_q[R0_WIDE_LOOP]) ? CP_MAX : $past(r2_q[R2_CP_LSB +: 4])))
        else $error("pump current wrong");
    a_mux_fastlock: assert property ( // RULE7 RULE9
        r1_q[R1_MUX_LSB +: 3] == MUX_FASTLOCK
        |=> mux_output_pin_oe_n_out == !$past(r0_q[R0_WIDE_LOOP]) && !mux_output_pin_out)
        else $error("fastlock switch wrong");
    a_resync_load: assert property ( // RULE8
        strobe_rise && shift_q[1:0] == SEL_REF && shift_q[R1_LOAD]
        |=> $stable(mod_pend_q) && resync_q == $past(shift_q[R1_MOD_LSB +: 12]))
        else $error("resync delay load disturbed modulus");
    a_lock_count: assert property ( // RULE10 RULE12
        $rose(lock_detect_out) |-> $past(ld_cnt_q) + 6'h01 == $past(ld_target)
        && $past(err_small) && $past(ref_edge))
        else $error("lock set at wrong count");
    a_lock_hold: assert property ( // RULE11
        lock_detect_out && !err_big && !new_channel && !pwr_dn |=> lock_detect_out)
        else $error("lock dropped without cause");
    a_lock_lose: assert property ( // RULE11
        lock_detect_out && err_big |=> !lock_detect_out)
        else $error("lock kept after large error");
    a_modulus_buffer: assert property ( // RULE16
        strobe_rise && shift_q[1:0] == SEL_REF |=> $stable(mod_act_q) ##1
        synth_cfg_out.fraction_modulus == $past(mod_act_q))
        else $error("modulus applied early");
    a_pwr_dn_effects: assert property ( // RULE17 RULE18 RULE20
        pwr_dn |=> synth_cfg_out.counter_reset && synth_cfg_out.cp_tristate
        && !lock_detect_out)
        else $error("power-down effects missing");
    a_pwr_dn_retain: assert property ( // RULE19
        pwr_dn && !strobe_rise |=> $stable(r0_q) && $stable(r1_q) && $stable(r3_q))
        else $error("registers lost in power-down");
    a_polarity: assert property ( // RULE21
        ##1 synth_cfg_out.pd_polarity == $past(r2_q[R2_POLARITY]))
        else $error("polarity not followed");
    a_ref_edge_sel: assert property ( // RULE23
        !r2_q[R2_DOUBLER] && ref_s && !prev_q[2] |-> !ref_edge)
        else $error("rising edge used without doubler");
    a_dither_mode: assert property ( // RULE24
        ##1 synth_cfg_out.dither_en == ($past(ns_mode) == NS_LOW_SPUR))
        else $error("dither mode wrong");
    a_low_noise_bias: assert property ( // RULE24
        ##1 synth_cfg_out.cp_low_noise == ($past(ns_mode) == NS_LOWEST))
        else $error("lowest noise bias wrong");
    a_latch_reference: assert property ( // RULE4
        strobe_rise && shift_q[1:0] == SEL_REF |=> r1_q == $past(shift_q) && $stable(r2_q))
        else $error("reference latch not loaded");
    a_latch_noise_spur: assert property ( // RULE4
        strobe_rise && shift_q[1:0] == SEL_NS |=> r3_q == $past(shift_q) && $stable(r0_q))
        else $error("noise and spur latch not loaded");
    a_modulus_pending: assert property ( // RULE16
        strobe_rise && shift_q[1:0] == SEL_REF && !shift_q[R1_LOAD]
        |=> mod_pend_q == $past(shift_q[R1_MOD_LSB +: 12]) && $stable(resync_q))
        else $error("pending modulus not stored");
    a_modulus_apply: assert property ( // RULE16
        new_channel |=> mod_act_q == $past(mod_pend_q))
        else $error("modulus not applied on divider write");
    a_channel_unlock: assert property ( // RULE11
        new_channel |=> !lock_detect_out)
        else $error("lock kept over new channel");
    a_pump_tristate: assert property ( // RULE18
        ##1 synth_cfg_out.cp_tristate ==
        ($past(r2_q[R2_CP_TRI]) || $past(pwr_dn)))
        else $error("pump three-state wrong");
    a_counter_hold: assert property ( // RULE17
        ##1 synth_cfg_out.counter_reset ==
        ($past(r2_q[R2_CNT_RST]) || $past(pwr_dn)))
        else $error("counter reset wrong");
    a_mux_lock_flag: assert property ( // RULE9
        r1_q[R1_MUX_LSB +: 3] == MUX_LOCK
        |=> !mux_output_pin_oe_n_out && mux_output_pin_out == $past(lock_detect_out))
        else $error("mux pin does not show lock");
    a_ref_both_edges: assert property ( // RULE23
        r2_q[R2_DOUBLER] && ref_s && !prev_q[2] |-> ref_edge)
        else $error("rising edge ignored with doubler");

    c_lock_reached: cover property ($rose(lock_detect_out));
    c_lock_lost: cover property (lock_detect_out ##1 !lock_detect_out);
    c_modulus_apply: cover property (new_channel ##1 $changed(mod_act_q));
    c_fastlock_pin: cover property (!mux_output_pin_oe_n_out && !mux_output_pin_out);
    c_precise_lock: cover property (r2_q[R2_LOCK_PREC] && $rose(lock_detect_out));
endmodule // fnsc_synth_ctrl
`default_nettype wire

// File: fnsc_pkg.sv
// package: field layout, codes, timing and types of the synthesizer control block
package fnsc_pkg;
    localparam int WORD_W = 24;
    localparam logic [23:0] REG_RST = 24'h00_0000;
    // register-select codes in the two lowest word bits
    localparam logic [1:0] SEL_DIV = 2'h0;
    localparam logic [1:0] SEL_REF = 2'h1;
    localparam logic [1:0] SEL_CTRL = 2'h2;
    localparam logic [1:0] SEL_NS = 2'h3;
    // divider_integer_fraction fields
    localparam int R0_FRACTION_NUMERATOR_LSB = 2;
    localparam int R0_INT_LSB = 14;
    localparam int R0_WIDE_LOOP = 23;
    // reference_divider_modulus fields
    localparam int R1_MOD_LSB = 2;
    localparam int R1_RCNT_LSB = 14;
    localparam int R1_PRESCALER = 18;
    localparam int R1_MUX_LSB = 20;
    localparam int R1_LOAD = 23;
    // synth_control fields
    localparam int R2_CNT_RST = 2;
    localparam int R2_CP_TRI = 3;
    localparam int R2_PWR_DN = 4;
    localparam int R2_LOCK_PREC = 5;
    localparam int R2_POLARITY = 6;
    localparam int R2_CP_LSB = 7;
    localparam int R2_DOUBLER = 11;
    localparam int R2_RESYNC_LSB = 12;
    // noise_spur_select mode bits: upper group and single low bit
    localparam int R3_MODE_HI_LSB = 6;
    localparam int R3_MODE_LO = 2;
    localparam logic [4:0] NS_LOW_SPUR = 5'h1c;
    localparam logic [4:0] NS_LOWEST = 5'h1f;
    // charge pump and multiplexer codes
    localparam logic [3:0] CP_MAX = 4'hf;
    localparam logic [2:0] MUX_LOCK = 3'h6;
    localparam logic [2:0] MUX_FASTLOCK = 3'h1;
    // lock detect timing
    localparam int CLK_NS = 10;
    localparam int LD_OK_NS = 15;
    localparam int LD_LOSE_NS = 30;
    localparam logic [3:0] LD_OK_CYC = 4'(LD_OK_NS / CLK_NS);
    localparam logic [3:0] LD_LOSE_CYC = 4'(LD_LOSE_NS / CLK_NS);
    localparam logic [5:0] LD_CNT_LO = 6'h18;
    localparam logic [5:0] LD_CNT_HI = 6'h28;

    typedef enum logic {LD_SEEK = 1'b0, LD_HELD = 1'b1} fnsc_ld_state_t;

    typedef struct packed {
        logic [8:0] int_value;
        logic [11:0] fraction_numerator;
        logic [11:0] fraction_modulus;
        logic [11:0] resync_delay;
        logic [3:0] ref_count;
        logic prescaler_select;
        logic [3:0] cp_current;
        logic cp_tristate;
        logic counter_reset;
        logic power_down;
        logic pd_polarity;
        logic ref_doubler;
        logic [3:0] resync_setting;
        logic dither_en;
        logic cp_low_noise;
    } fnsc_cfg_t;
endpackage

// File: fnsc_host_model.sv
// host model: drives the three-wire serial port with a 160 ns serial clock
`timescale 1ns/1ps
`default_nettype none
module fnsc_host_model (
    input wire logic mclk_in,
    output logic serial_clk_out,
    output logic serial_data_out,
    output logic latch_strobe_out
);
    // waits whole clock periods, then steps just past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask
    // one word, msb first; serial clock stands low outside the frame
    task automatic send_word(input logic [23:0] word);
        for (int i = 23; i >= 0; i--) begin
            serial_data_out = word[i];
            tick(4);
            serial_clk_out = 1'b1;
            tick(8);
            serial_clk_out = 1'b0;
            tick(4);
        end
        serial_data_out = ~word[0]; // released data shows the inverse of the last bit
        latch_strobe_out = 1'b1;
        tick(8);
        latch_strobe_out = 1'b0;
        tick(4);
    endtask
    // idle levels from time zero
    initial begin
        serial_clk_out = 1'b0;
        serial_data_out = 1'b0;
        latch_strobe_out = 1'b0;
    end
endmodule // fnsc_host_model
`default_nettype wire

// File: fnsc_synth_ctrl_tb.sv
// testbench: register writes, modulus buffering, lock detect and mux pin checks
`timescale 1ns/1ps
`default_nettype none
module fnsc_synth_ctrl_tb;
    import fnsc_pkg::*;
    localparam logic [23:0] MASK [4] = '{24'hff_fffc, 24'hf7_fffc, 24'h00_fffc, 24'h00_03c4};
    logic mclk_in, sys_rst_in, sclk, sdat, strobe, ref_in, up_in, dn_in, lock, pin, pin_oe_n;
    fnsc_cfg_t cfg;
    logic [23:0] r [4];
    logic [11:0] mod_pend, mod_act, resync;
    logic [1:0] s;
    int err_total, check_count;
    fnsc_host_model host (.mclk_in(mclk_in), .serial_clk_out(sclk), .serial_data_out(sdat),
        .latch_strobe_out(strobe));
    fnsc_synth_ctrl uut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .serial_clk_in(sclk),
        .serial_data_in(sdat), .latch_strobe_in(strobe), .reference_input_in(ref_in),
        .phase_comparator_up_in(up_in), .phase_comparator_dn_in(dn_in), .synth_cfg_out(cfg),
        .lock_detect_out(lock), .mux_output_pin_out(pin), .mux_output_pin_oe_n_out(pin_oe_n));
    // 100 MHz clock
    initial begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end
    // expected decoded configuration from the written words
    function automatic fnsc_cfg_t exp_cfg();
        fnsc_cfg_t c;
        logic [4:0] m;
        m = {r[3][9:6], r[3][2]};
        c.int_value = r[0][22:14];
        c.fraction_numerator = r[0][13:2];
        c.fraction_modulus = mod_act;
        c.resync_delay = resync;
        c.ref_count = r[1][17:14];
        c.prescaler_select = r[1][18];
        c.cp_current = r[0][23] ? CP_MAX : r[2][10:7];
        c.cp_tristate = r[2][3] | r[2][4];
        c.counter_reset = r[2][2] | r[2][4];
        c.power_down = r[2][4];
        c.pd_polarity = r[2][6];
        c.ref_doubler = r[2][11];
        c.resync_setting = r[2][15:12];
        c.dither_en = (m == NS_LOW_SPUR);
        c.cp_low_noise = (m == NS_LOWEST);
        return c;
    endfunction
    // expected mux pin enable
    function automatic logic exp_oe_n();
        case (r[1][22:20])
            MUX_FASTLOCK: return ~r[0][23];
            MUX_LOCK: return 1'b0;
            default: return 1'b1;
        endcase
    endfunction
    // random word that keeps the host-side programming limits
    function automatic logic [23:0] legal_word(input logic [1:0] sel);
        logic [23:0] w;
        w = (24'($urandom()) & MASK[sel]) | 24'(sel);
        if (sel == SEL_DIV) begin
            w[22:14] = (r[1][18] ? 9'h05b : 9'h01f) + 9'($urandom_range(420));
            w[13:2] = 12'($urandom_range(mod_pend));
        end
        if (sel == SEL_REF) begin
            w[17:14] = 4'($urandom_range(15, 1));
            w[18] = w[18] & (r[0][22:14] >= 9'h05b);
        end
        return w;
    endfunction
    task automatic chk_cfg(input fnsc_cfg_t got, input fnsc_cfg_t exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: config %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string what);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: %s is %b expected %b", $time, what, got, exp);
        end
    endtask
    task automatic tdone(input string name);
        $display("test %s done", name);
    endtask
    // one serial write, model update, then config and mux pin enable compare
    task automatic wr(input logic [23:0] w);
        host.send_word(w);
        r[w[1:0]] = w;
        if (w[1:0] == SEL_DIV) mod_act = mod_pend;
        if (w[1:0] == SEL_REF && w[23]) resync = w[13:2];
        if (w[1:0] == SEL_REF && !w[23]) mod_pend = w[13:2];
        chk_cfg(cfg, exp_cfg());
        chk_bit(pin_oe_n, exp_oe_n(), "mux enable");
    endtask
    // n reference cycles; big gives a 5 cycle error pulse, else 0 or 1 cycle
    task automatic refc(input int n, input bit big);
        int e;
        repeat (n) begin
            e = big ? 5 : int'($urandom_range(1));
            ref_in = 1'b1;
            if (big) dn_in = 1'b1;
            else up_in = (e > 0);
            host.tick(e);
            up_in = 1'b0;
            dn_in = 1'b0;
            host.tick(10 - e);
            ref_in = 1'b0;
            host.tick(10);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // hang guard
    initial begin
        #900_000;
        err_total++;
        $display("Error at %0t: run timed out", $time);
        results();
    end
    // main sequence
    initial begin
        err_total = 0;
        check_count = 0;
        {sys_rst_in, ref_in, up_in, dn_in} = 4'b1000;
        r = '{default: '0};
        {mod_pend, mod_act, resync} = '0;
        void'($urandom(32'h41b3));
        host.tick(4);
        sys_rst_in = 1'b0;
        host.tick(3);
        chk_cfg(cfg, exp_cfg());
        chk_bit(lock, 1'b0, "lock after reset");
        for (int i = 0; i < 4; i++) wr(24'h00_0383 + 24'(i == 1) * 24'h44);
        wr(24'h00_0003);
        wr(24'h60_4105);
        wr(24'he0_448d);
        wr(24'h0a_0080);
        wr(24'h00_0002);
        tdone("modes and modulus");
        refc(1, 1'b1);
        refc(23, 1'b0);
        chk_bit(lock, 1'b0, "lock after 23");
        refc(1, 1'b0);
        chk_bit(lock, 1'b1, "lock after 24");
        chk_bit(pin, 1'b1, "mux lock");
        refc(1, 1'b1);
        chk_bit(lock, 1'b0, "lock after error");
        refc(24, 1'b0);
        wr(24'h0a_0080);
        chk_bit(lock, 1'b0, "lock after channel");
        wr(24'h00_0822);
        refc(1, 1'b1);
        refc(19, 1'b0);
        ref_in = 1'b1;
        host.tick(10);
        chk_bit(lock, 1'b0, "lock after 39");
        ref_in = 1'b0;
        host.tick(10);
        chk_bit(lock, 1'b1, "lock after 40");
        wr(24'h00_0832);
        chk_bit(lock, 1'b0, "lock in power-down");
        wr(24'h0b_0100);
        wr(24'h00_0042);
        tdone("lock detect");
        wr(24'h10_4105);
        wr(24'h8b_0100);
        chk_bit(pin, 1'b0, "fastlock pin");
        wr(24'h0b_0100);
        tdone("fastlock");
        repeat (24) begin
            s = 2'($urandom());
            wr(legal_word(s));
        end
        tdone("random writes");
        results();
    end
endmodule // fnsc_synth_ctrl_tb
`default_nettype wire
